// ==== sft_map.vh ====
// Register map, field positions, reset values and timing counts of the safety timer.
`ifndef SFT_MAP_VH
`define SFT_MAP_VH

// Register indices; the byte address on the bus is four times the index.
`define SFT_IDX_CTRL_A 16'h3030
`define SFT_IDX_CTRL_B 16'h3031
`define SFT_IDX_CNT_H 16'h3032
`define SFT_IDX_CNT_L 16'h3033
`define SFT_IDX_TO_H 16'h3034
`define SFT_IDX_TO_L 16'h3035
`define SFT_IDX_WIN_H 16'h3036
`define SFT_IDX_WIN_L 16'h3037
`define SFT_IDX_BASE 16'h3030
`define SFT_IDX_LAST 16'h3037

// Local register numbers (index minus base).
`define SFT_R_CTRL_A 3'h0
`define SFT_R_CTRL_B 3'h1
`define SFT_R_CNT_H 3'h2
`define SFT_R_CNT_L 3'h3
`define SFT_R_TO_H 3'h4
`define SFT_R_TO_L 3'h5
`define SFT_R_WIN_H 3'h6
`define SFT_R_WIN_L 3'h7

// Reset values.
`define SFT_RST_CTRL_A 8'h80
`define SFT_RST_CTRL_B 8'h01
`define SFT_RST_CNT 16'h0000
`define SFT_RST_TO_H 8'h09
`define SFT_RST_TO_L 8'hc4
`define SFT_RST_WIN 8'h00
`define SFT_RST_CHK 2'h0

// Fields of ctrl_status_a.
`define SFT_A_RUN 7
`define SFT_A_IRQ 6
`define SFT_A_UPD 5
`define SFT_A_CHK_HI 4
`define SFT_A_CHK_LO 3
`define SFT_A_HALT 2
`define SFT_A_IDLE 1
`define SFT_A_SLEEP 0

// Fields of ctrl_status_b.
`define SFT_B_WIN 7
`define SFT_B_FLG 6
`define SFT_B_PRES 4
`define SFT_B_CLK_HI 1
`define SFT_B_CLK_LO 0

// Self-check mode encodings.
`define SFT_CHK_LOW 2'h2
`define SFT_CHK_HIGH 2'h3

// Key words of the two write sequences.
`define SFT_KEY_REF1 16'ha602
`define SFT_KEY_REF2 16'hb480
`define SFT_KEY_UNL1 16'hc520
`define SFT_KEY_UNL2 16'hd928

// Timing counts, given in bus clocks, which are pclk cycles here.
`define SFT_SEQ_CLKS 16
`define SFT_UNL_CLKS 128
`define SFT_DLY_CLKS 128
`define SFT_SEQ_LIMIT 8'd16
`define SFT_UNL_LIMIT 8'd128
`define SFT_DLY_LIMIT 8'd128
`define SFT_CNT_ONE 8'h01
`define SFT_CNT_ZERO 8'h00

`endif

// ==== sft_top.v ====
// Safety timer control registers, counter, refresh/unlock sequences and reset request logic.
`timescale 1ns/100ps
// Notes on behaviour
// - Run bit 7 enables counting.
// - Interrupt bit: request interrupt before reset.
// - Reset 128 clocks after vector fetch.
// - Without interrupt bit, reset at once.
// - Update bit 0 freezes configuration.
// - Reconfiguration accepted within 128 clocks after unlock.
// - Self-check mode selects compare bytes.
// - Self-check mode cleared by power-on only.
// - Halt bit keeps counting in debug.
// - Idle bit keeps counting in wait.
// - Sleep bit keeps counting in stop.
// - Control registers reset to 80h, 01h.
// - Timeout bytes reset 09h, C4h, writable.
// - Counter bytes read-only, reset zero.
// - Window bytes writable, reset zero.
// - Refresh A602 then B480 within 16 clocks.
// - Unlock C520 then D928 within 16 clocks.
// - Other counter writes force a reset.
// - Counter reaching timeout forces a reset.
`include "sft_map.vh"

module sft_top
(
  input wire pclk,
  input wire presetn,
  input wire por_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [15:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire debug_mode,
  input wire wait_mode,
  input wire stop_mode,
  input wire vector_fetch,
  output wire irq_req,
  output reg sys_reset_req
);

  localparam ST_RUN = 4'b0001;
  localparam ST_VEC = 4'b0010;
  localparam ST_DLY = 4'b0100;
  localparam ST_RST = 4'b1000;
  localparam SQ_IDLE = 3'b001;
  localparam SQ_REF = 3'b010;
  localparam SQ_UNL = 3'b100;

  // Decode a byte address into {hit, local register number}.
  function [3:0] sft_dec;
    input [15:0] addr;
    reg [15:0] idx;
    begin
      idx = {2'b00, addr[15:2]};
      if ((addr[1:0] == 2'b00) && (idx >= `SFT_IDX_BASE) && (idx <= `SFT_IDX_LAST))
        sft_dec = {1'b1, idx[2:0]};
      else
        sft_dec = 4'h0;
    end
  endfunction

  wire [3:0] dec_w;
  wire hit_w;
  wire [2:0] reg_w;
  wire wr_w;
  wire [7:0] wbyte_w;
  wire [7:0] wr_sel;
  reg [7:0] ctrl_a_r;
  reg [1:0] chk_r;
  reg [7:0] ctrl_b_r;
  reg [7:0] to_h_r;
  reg [7:0] to_l_r;
  reg [7:0] win_h_r;
  reg [7:0] win_l_r;
  reg [15:0] cnt_r;
  reg [7:0] done_r;
  reg [7:0] hi_byte_r;
  reg hi_pend_r;
  reg [2:0] seq_r;
  reg [7:0] seq_cnt_r;
  reg unl_open_r;
  reg [7:0] unl_cnt_r;
  reg [3:0] st_r;
  reg [7:0] dly_cnt_r;
  reg [2:0] mode_s1_r;
  reg [2:0] mode_s2_r;
  reg [7:0] rd_nxt;
  wire [15:0] word_w;
  wire word_done_w;
  wire lo_orphan_w;
  wire ref_done_w;
  wire unl_done_w;
  wire illegal_w;
  wire run_w;
  wire hit_to_w;
  wire event_w;
  wire flg_clr_w;
  reg hit_to_w_c;

  assign dec_w = sft_dec(paddr);
  assign hit_w = dec_w[3];
  assign reg_w = dec_w[2:0];
  // Zero wait states; read data is prepared in the setup cycle.
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_w;
  assign wr_w = psel & penable & pwrite & hit_w;
  assign wbyte_w = pwdata[7:0];

  // One write strobe per register; unmapped or misaligned addresses raise none.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_sel
      assign wr_sel[gi] = wr_w && ({29'h0, reg_w} == gi);
    end
  endgenerate

  // Mode pins come from the chip's power controller, so they are synchronised.
  // Two flip-flops guard against metastability; a mode change acts two clocks late.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_s1_r <= 3'h0;
      mode_s2_r <= 3'h0;
    end
    else
    begin
      mode_s1_r <= {stop_mode, wait_mode, debug_mode};
      mode_s2_r <= mode_s1_r;
    end
  end

  assign run_w = ctrl_a_r[`SFT_A_RUN] && (st_r == ST_RUN)
    && !(mode_s2_r[0] && !ctrl_a_r[`SFT_A_HALT])
    && !(mode_s2_r[1] && !ctrl_a_r[`SFT_A_IDLE])
    && !(mode_s2_r[2] && !ctrl_a_r[`SFT_A_SLEEP]);

  // Counter writes pair as high byte then low byte into one 16-bit word.
  assign word_w = {hi_byte_r, wbyte_w};
  assign word_done_w = wr_sel[`SFT_R_CNT_L] && hi_pend_r;
  assign lo_orphan_w = wr_sel[`SFT_R_CNT_L] && !hi_pend_r;
  assign ref_done_w = word_done_w && (seq_r == SQ_REF) && (word_w == `SFT_KEY_REF2);
  assign unl_done_w = word_done_w && (seq_r == SQ_UNL) && (word_w == `SFT_KEY_UNL2)
    && ctrl_a_r[`SFT_A_UPD];
  // An unlock with updates forbidden counts as an illegal write.
  assign illegal_w = lo_orphan_w || (word_done_w && !ref_done_w && !unl_done_w
    && !((seq_r == SQ_IDLE) && ((word_w == `SFT_KEY_REF1) || (word_w == `SFT_KEY_UNL1))));

  always @*
  begin
    case (chk_r)
      `SFT_CHK_LOW: hit_to_w_c = (cnt_r[7:0] == to_l_r);
      `SFT_CHK_HIGH: hit_to_w_c = (cnt_r[15:8] == to_h_r);
      default: hit_to_w_c = (cnt_r == {to_h_r, to_l_r});
    endcase
  end
  assign hit_to_w = run_w && hit_to_w_c;
  assign event_w = (st_r == ST_RUN) && (hit_to_w || illegal_w);
  // Software clears the flag by writing a one to it.
  assign flg_clr_w = wr_sel[`SFT_R_CTRL_B] && wbyte_w[`SFT_B_FLG];
  assign irq_req = ctrl_b_r[`SFT_B_FLG] && ctrl_a_r[`SFT_A_IRQ];

  // Refresh and unlock sequence tracker.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hi_byte_r <= 8'h00;
      hi_pend_r <= 1'b0;
      seq_r <= SQ_IDLE;
      seq_cnt_r <= `SFT_CNT_ZERO;
    end
    else
    begin
      if (wr_sel[`SFT_R_CNT_H])
      begin
        hi_byte_r <= wbyte_w;
        hi_pend_r <= 1'b1;
      end
      else if (wr_sel[`SFT_R_CNT_L])
        hi_pend_r <= 1'b0;
      case (seq_r)
        SQ_IDLE:
        begin
          seq_cnt_r <= `SFT_CNT_ZERO;
          if (word_done_w && (word_w == `SFT_KEY_REF1))
            seq_r <= SQ_REF;
          else if (word_done_w && (word_w == `SFT_KEY_UNL1))
            seq_r <= SQ_UNL;
        end
        SQ_REF, SQ_UNL:
        begin
          seq_cnt_r <= seq_cnt_r + `SFT_CNT_ONE;
          // A second word missing for 16 clocks abandons the sequence.
          if (word_done_w || (seq_cnt_r >= `SFT_SEQ_LIMIT - `SFT_CNT_ONE))
            seq_r <= SQ_IDLE;
        end
        default: seq_r <= SQ_IDLE;
      endcase
    end
  end

  // Unlock window: config fields reopen for 128 clocks, then relock.
  // Expiry locks even registers never written, so software must finish in time.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      unl_open_r <= 1'b0;
      unl_cnt_r <= `SFT_CNT_ZERO;
    end
    else if (unl_done_w)
    begin
      unl_open_r <= 1'b1;
      unl_cnt_r <= `SFT_CNT_ZERO;
    end
    else if (unl_open_r)
    begin
      unl_cnt_r <= unl_cnt_r + `SFT_CNT_ONE;
      if (unl_cnt_r >= `SFT_UNL_LIMIT - `SFT_CNT_ONE)
        unl_open_r <= 1'b0;
    end
  end

  // Write-once tracking per register; closing the unlock window locks all.
  // Counter writes set their bits too, which is harmless because they store nothing.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      done_r <= 8'h00;
    else if (unl_done_w)
      done_r <= 8'h00;
    else if (unl_open_r && (unl_cnt_r >= `SFT_UNL_LIMIT - `SFT_CNT_ONE))
      done_r <= 8'hff;
    else
      done_r <= done_r | wr_sel;
  end

  // Configuration registers, each taking only its first write.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_a_r <= `SFT_RST_CTRL_A;
      ctrl_b_r <= `SFT_RST_CTRL_B;
      to_h_r <= `SFT_RST_TO_H;
      to_l_r <= `SFT_RST_TO_L;
      win_h_r <= `SFT_RST_WIN;
      win_l_r <= `SFT_RST_WIN;
    end
    else
    begin
      if (wr_sel[`SFT_R_CTRL_A] && !done_r[`SFT_R_CTRL_A])
        ctrl_a_r <= wbyte_w;
      if (wr_sel[`SFT_R_CTRL_B] && !done_r[`SFT_R_CTRL_B])
      begin
        ctrl_b_r[`SFT_B_WIN] <= wbyte_w[`SFT_B_WIN];
        ctrl_b_r[`SFT_B_PRES] <= wbyte_w[`SFT_B_PRES];
        ctrl_b_r[`SFT_B_CLK_HI:`SFT_B_CLK_LO] <= wbyte_w[`SFT_B_CLK_HI:`SFT_B_CLK_LO];
      end
      // The flag is write-one-to-clear; a new event in the same cycle wins.
      if (event_w && ctrl_a_r[`SFT_A_IRQ])
        ctrl_b_r[`SFT_B_FLG] <= 1'b1;
      else if (flg_clr_w)
        ctrl_b_r[`SFT_B_FLG] <= 1'b0;
      if (wr_sel[`SFT_R_TO_H] && !done_r[`SFT_R_TO_H])
        to_h_r <= wbyte_w;
      if (wr_sel[`SFT_R_TO_L] && !done_r[`SFT_R_TO_L])
        to_l_r <= wbyte_w;
      if (wr_sel[`SFT_R_WIN_H] && !done_r[`SFT_R_WIN_H])
        win_h_r <= wbyte_w;
      if (wr_sel[`SFT_R_WIN_L] && !done_r[`SFT_R_WIN_L])
        win_l_r <= wbyte_w;
    end
  end

  // Self-check mode survives every reset except power-on.
  always @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
      chk_r <= `SFT_RST_CHK;
    else if (wr_sel[`SFT_R_CTRL_A] && !done_r[`SFT_R_CTRL_A])
      chk_r <= wbyte_w[`SFT_A_CHK_HI:`SFT_A_CHK_LO];
  end

  // Counter; it holds once a reset-triggering event has been taken.
  // It wraps at 16 bits, so a timeout set below the count waits a full turn.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_r <= `SFT_RST_CNT;
    else if (ref_done_w)
      cnt_r <= `SFT_RST_CNT;
    else if (run_w)
      cnt_r <= cnt_r + 16'h0001;
  end

  // Reset sequencer. The reset request stays high until system reset arrives.
  // The delay count is cleared while running, so every delay starts from zero.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= ST_RUN;
      dly_cnt_r <= `SFT_CNT_ZERO;
      sys_reset_req <= 1'b0;
    end
    else
    begin
      case (st_r)
        ST_RUN:
        begin
          dly_cnt_r <= `SFT_CNT_ZERO;
          if (event_w && ctrl_a_r[`SFT_A_IRQ])
            st_r <= ST_VEC;
          else if (event_w)
          begin
            st_r <= ST_RST;
            sys_reset_req <= 1'b1;
          end
        end
        ST_VEC:
        begin
          if (vector_fetch)
            st_r <= ST_DLY;
        end
        ST_DLY:
        begin
          dly_cnt_r <= dly_cnt_r + `SFT_CNT_ONE;
          if (dly_cnt_r >= `SFT_DLY_LIMIT - `SFT_CNT_ONE)
          begin
            st_r <= ST_RST;
            sys_reset_req <= 1'b1;
          end
        end
        ST_RST: sys_reset_req <= 1'b1;
        default: st_r <= ST_RUN;
      endcase
    end
  end

  // Read mux; reserved bits of ctrl_status_b read as zero.
  always @*
  begin
    case (reg_w)
      `SFT_R_CTRL_A: rd_nxt = {ctrl_a_r[7:5], chk_r, ctrl_a_r[2:0]};
      `SFT_R_CTRL_B: rd_nxt = {ctrl_b_r[7:6], 1'b0, ctrl_b_r[4], 2'b00, ctrl_b_r[1:0]};
      `SFT_R_CNT_H: rd_nxt = cnt_r[15:8];
      `SFT_R_CNT_L: rd_nxt = cnt_r[7:0];
      `SFT_R_TO_H: rd_nxt = to_h_r;
      `SFT_R_TO_L: rd_nxt = to_l_r;
      `SFT_R_WIN_H: rd_nxt = win_h_r;
      default: rd_nxt = win_l_r;
    endcase
  end

  // Data is taken in the setup cycle so that the access phase needs no wait state.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable)
      prdata <= hit_w ? {24'h000000, rd_nxt} : 32'h00000000;
  end

endmodule

// ==== sft_checker.sv ====
// Checker of the safety timer bus answers and reset request behaviour.
`timescale 1ns/100ps
module sft_checker
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [15:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire vector_fetch,
  input wire irq_req,
  input wire sys_reset_req
);
  reg hi_pend_r;
  reg [7:0] hi_byte_r;
  reg fetched_r;
  wire wr_done = psel && penable && pwrite;
  wire [15:0] word = {hi_byte_r, pwdata[7:0]};
  wire key_ok = word == 16'ha602 || word == 16'hb480 || word == 16'hc520 || word == 16'hd928;
  wire bad_word = wr_done && paddr == 16'hc0cc && !(hi_pend_r && key_ok);
  wire unmapped = paddr < 16'hc0c0 || paddr > 16'hc0dc || paddr[1:0] != 2'h0;
  // A low byte only makes a word with the high byte written before it.
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      hi_pend_r <= 1'b0;
      hi_byte_r <= 8'h00;
      fetched_r <= 1'b0;
    end
    else
    begin
      if (wr_done && paddr == 16'hc0c8)
      begin
        hi_pend_r <= 1'b1;
        hi_byte_r <= pwdata[7:0];
      end
      else if (wr_done && paddr == 16'hc0cc)
        hi_pend_r <= 1'b0;
      if (vector_fetch && irq_req)
        fetched_r <= 1'b1;
    end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_reset_held: assert property (sys_reset_req |=> sys_reset_req)
    else $error("reset request dropped");
  a_illegal_word: assert property (bad_word |=> sys_reset_req || irq_req)
    else $error("illegal counter write ignored");
  a_fetch_delay: assert property (vector_fetch && irq_req && !sys_reset_req |-> ##128 !sys_reset_req ##1 sys_reset_req)
    else $error("reset delay after vector fetch wrong");
  a_irq_first: assert property (irq_req && !fetched_r && !vector_fetch |=> !sys_reset_req)
    else $error("reset before vector fetch");
  a_slverr_map: assert property (psel && penable |-> pslverr == unmapped)
    else $error("error response wrong for address");
  a_prdata_stand: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data changed outside setup");
  a_upper_zero: assert property (prdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_ready_const: assert property (pready)
    else $error("wait state inserted");
endmodule
bind sft_top sft_checker i_sft_checker (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .vector_fetch(vector_fetch), .irq_req(irq_req), .sys_reset_req(sys_reset_req));

// ==== sft_top_test.sv ====
// Self-checking testbench of the safety timer registers and reset request.
`timescale 1ns/100ps
module sft_top_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic por_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic debug_mode = 1'b0;
  logic wait_mode = 1'b0;
  logic stop_mode = 1'b0;
  logic vector_fetch = 1'b0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire irq_req;
  wire sys_reset_req;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;
  int t;
  logic [31:0] q;
  logic [31:0] q2;
  logic err;
  logic [7:0] d;
  logic [7:0] hb;
  localparam logic [63:0] RV = 64'h0000c40900000180;
  sft_top i_sft_top (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .debug_mode(debug_mode), .wait_mode(wait_mode), .stop_mode(stop_mode), .vector_fetch(vector_fetch),
    .irq_req(irq_req), .sys_reset_req(sys_reset_req));
  always #5 pclk = ~pclk;
  task finish_test;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fail_count++;
      finish_test;
    end
  end
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One idle cycle follows each transfer, so no strobe is driven twice at one edge.
  task apb(input logic w, input logic [15:0] a, input logic [7:0] dv);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, dv};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [2:0] r, input logic [7:0] dv);
    apb(1'b1, 16'hc0c0 + {11'h000, r, 2'b00}, dv);
  endtask
  task rd(input logic [2:0] r);
    apb(1'b0, 16'hc0c0 + {11'h000, r, 2'b00}, 8'h00);
  endtask
  task key(input logic [7:0] h, input logic [7:0] l);
    wr(3'h2, h);
    wr(3'h3, l);
  endtask
  task rst(input logic p);
    presetn <= 1'b0;
    por_n <= ~p;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    @(posedge pclk);
  endtask
  task wait_rst(input int mx);
    n = 0;
    while (sys_reset_req !== 1'b1 && n < mx)
    begin
      @(posedge pclk);
      n++;
    end
  endtask
  function int tgt(input int m, input logic [7:0] h, input logic [7:0] l);
    if (m == 2)
      return l;
    if (m == 3)
      return h * 256;
    return h * 256 + l;
  endfunction
  initial
  begin
    q2 = $urandom(61);
    rst(1'b1);
    check("reset request idle", sys_reset_req, 1'b0);
    for (int r = 0; r < 8; r++)
      if (r != 3)
      begin
        rd(r[2:0]);
        check("reset value", q, {24'h0, RV[r*8 +: 8]});
      end
    for (int r = 4; r < 8; r++)
    begin
      d = $urandom;
      wr(r[2:0], d);
      rd(r[2:0]);
      check("rw value", q, {24'h0, d});
    end
    apb(1'b1, 16'hc0e1, 8'h55);
    check("unmapped error", err, 1'b1);
    apb(1'b0, 16'hc0c4, 8'h00);
    check("mapped error", err, 1'b0);
    rst(1'b1);
    wr(3'h0, 8'h88);
    wr(3'h0, 8'h00);
    rd(3'h0);
    check("write once", q, 32'h88);
    rst(1'b0);
    rd(3'h0);
    check("check mode kept", q, 32'h88);
    rst(1'b1);
    rd(3'h0);
    check("check mode cleared", q, 32'h80);
    for (int i = 0; i < 4; i++)
    begin
      rst(1'b1);
      hb = (i == 2) ? 8'h30 : (i == 3) ? 8'h01 : 8'h00;
      d = (i == 3) ? 8'hf0 : 8'h40 + 8'($urandom_range(63));
      wr(3'h0, 8'h80 | 8'(i << 3));
      wr(3'h4, hb);
      wr(3'h5, d);
      key(8'ha6, 8'h02);
      key(8'hb4, 8'h80);
      wait_rst(1000);
      t = tgt(i, hb, d);
      check("timeout cycles", n >= t - 3 && n <= t + 3, 1'b1);
      check("no irq", irq_req, 1'b0);
    end
    rst(1'b1);
    wr(3'h0, 8'hc0);
    wr(3'h4, 8'h00);
    wr(3'h5, 8'h40);
    n = 0;
    while (irq_req !== 1'b1 && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    check("irq raised", irq_req, 1'b1);
    check("reset held", sys_reset_req, 1'b0);
    vector_fetch <= 1'b1;
    @(posedge pclk);
    vector_fetch <= 1'b0;
    wait_rst(300);
    // The rise lands 128 edges after the fetch edge and is seen one edge later.
    check("fetch delay", n, 129);
    rd(3'h1);
    check("flag set", q, 32'h41);
    wr(3'h1, 8'h40);
    rd(3'h1);
    check("flag cleared", q, 32'h00);
    check("irq cleared", irq_req, 1'b0);
    for (int i = 0; i < 2; i++)
    begin
      rst(1'b1);
      if (i == 0)
        wr(3'h3, $urandom);
      else
        key(8'ha6, 8'h03);
      repeat (2) @(posedge pclk);
      check("illegal write", sys_reset_req, 1'b1);
    end
    rst(1'b1);
    wr(3'h0, 8'h80);
    key(8'hc5, 8'h20);
    key(8'hd9, 8'h28);
    repeat (2) @(posedge pclk);
    check("frozen unlock", sys_reset_req, 1'b1);
    rst(1'b1);
    wr(3'h0, 8'ha0);
    key(8'hc5, 8'h20);
    key(8'hd9, 8'h28);
    wr(3'h0, 8'h20);
    rd(3'h0);
    check("unlocked write", q, 32'h20);
    rd(3'h3);
    q2 = q;
    rd(3'h3);
    check("stopped counter", q, q2);
    repeat (140) @(posedge pclk);
    wr(3'h0, 8'ha0);
    rd(3'h0);
    check("window closed", q, 32'h20);
    for (int i = 0; i < 6; i++)
    begin
      rst(1'b1);
      wr(3'h0, 8'h80 | 8'((i % 2) << (i / 2)));
      {debug_mode, wait_mode, stop_mode} <= 3'b001 << (i / 2);
      repeat (4) @(posedge pclk);
      rd(3'h3);
      q2 = q;
      rd(3'h3);
      check("mode counting", q !== q2, i % 2);
      {debug_mode, wait_mode, stop_mode} <= 3'b000;
    end
    finish_test;
  end
endmodule
